// ### verilog/sil_pkg.sv
package sil_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int DIAG_BIT_NS  = 100_000;
  localparam int DIAG_BIT_CYC = DIAG_BIT_NS / (1_000_000_000 / CLK_HZ);
  localparam int ATTACH_MS    = 10;
  localparam int ATTACH_CYC   = ATTACH_MS * (CLK_HZ / 1000);
  localparam int BLINK_MS     = 250;
  localparam int BLINK_CYC    = BLINK_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Register map
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS = 8'h04;
  localparam logic [7:0]  OFF_SERIAL = 8'h08;
  localparam logic [7:0]  OFF_TEACH  = 8'h0c;
  localparam logic [7:0]  OFF_NAME   = 8'h10;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [7:0]  TEACH_RST  = 8'h08;
  // Arbitrary neutral value
  localparam logic [15:0] SERIAL_DEF = 16'h1234;
  localparam int          STS_PERR_BIT = 7;

  // ==========================================================
  // Diagnostic link
  localparam int         CHAIN_MAX = 16;
  localparam int         CHAIN_W   = $clog2(CHAIN_MAX);
  localparam int         TX_BITS   = 20;
  localparam logic [3:0] CMD_STATUS   = 4'h0;
  localparam logic [3:0] CMD_SERIAL   = 4'h1;
  localparam logic [3:0] CMD_TEACH    = 4'h2;
  localparam logic [3:0] CMD_NAME     = 4'h3;
  localparam logic [3:0] CMD_NAME_UPD = 4'h4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ch1;
    logic ch2;
  } sil_pair_s;

  typedef struct packed {
    logic [CHAIN_W-1:0] chain_addr;
    logic [2:0]         rsvd;
    logic               force_safe;
  } sil_ctrl_s;

  typedef struct packed {
    logic ready;
    logic link;
    logic perr;
    logic lock;
    logic unequal;
    logic out2;
    logic out1;
    logic in2;
    logic in1;
    logic present;
  } sil_status_s;

  typedef struct packed {
    logic [CHAIN_W-1:0] addr;
    logic [3:0]         code;
  } sil_cmd_s;

  typedef struct packed {
    logic actuator;
    logic in_green;
    logic in_yellow;
    logic pwr_green;
    logic fault_red;
  } sil_led_s;

endpackage : sil_pkg

// ### verilog/sil_sync.sv
`timescale 1ns/10ps
module sil_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sil_sync_s;

  sil_sync_s st_r;
  sil_sync_s st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : sil_sync

// ### verilog/sil_diag_link.sv
`timescale 1ns/10ps
module sil_diag_link #(
  parameter int BIT_CYC = sil_pkg::DIAG_BIT_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rx,
  input  wire logic        tx_start,
  input  wire logic [15:0] tx_word,
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  output logic             tx_busy,
  output logic             tx
);

  localparam int CW = $clog2(BIT_CYC + 1);
  localparam int NW = $clog2(sil_pkg::TX_BITS + 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sil_rx_e;

  typedef struct packed {
    sil_rx_e                       rx_st;
    logic [CW-1:0]                 rx_cnt;
    logic [2:0]                    rx_n;
    logic [7:0]                    rx_sh;
    logic                          rx_v;
    logic [7:0]                    rx_b;
    logic [sil_pkg::TX_BITS-1:0]   tx_sh;
    logic [NW-1:0]                 tx_n;
    logic [CW-1:0]                 tx_cnt;
    logic                          tx_line;
  } sil_link_s;

  sil_link_s st_r;
  sil_link_s s;

  // ==========================================================
  // Receive and transmit, 8N1 framing, LSB first
  always_comb begin
    s      = st_r;
    s.rx_v = 1'b0;
    unique case (st_r.rx_st)
      RX_IDLE: if (!rx) begin
        s.rx_st  = RX_START;
        s.rx_cnt = '0;
      end
      RX_START: if (st_r.rx_cnt == CW'(BIT_CYC / 2 - 1)) begin
        // Glitch shorter than half a bit is dropped
        s.rx_st  = rx ? RX_IDLE : RX_DATA;
        s.rx_cnt = '0;
        s.rx_n   = '0;
      end else begin
        s.rx_cnt = st_r.rx_cnt + 1'b1;
      end
      RX_DATA: if (st_r.rx_cnt == CW'(BIT_CYC - 1)) begin
        s.rx_cnt = '0;
        s.rx_sh  = {rx, st_r.rx_sh[7:1]};
        s.rx_n   = st_r.rx_n + 1'b1;
        if (&st_r.rx_n) begin
          s.rx_st = RX_STOP;
        end
      end else begin
        s.rx_cnt = st_r.rx_cnt + 1'b1;
      end
      RX_STOP: if (st_r.rx_cnt == CW'(BIT_CYC - 1)) begin
        s.rx_st = RX_IDLE;
        s.rx_v  = rx;
        s.rx_b  = st_r.rx_sh;
      end else begin
        s.rx_cnt = st_r.rx_cnt + 1'b1;
      end
    endcase
    if (st_r.tx_n != '0) begin
      if (st_r.tx_cnt == CW'(BIT_CYC - 1)) begin
        s.tx_cnt  = '0;
        s.tx_line = st_r.tx_sh[0];
        s.tx_sh   = st_r.tx_sh >> 1;
        s.tx_n    = st_r.tx_n - 1'b1;
      end else begin
        s.tx_cnt = st_r.tx_cnt + 1'b1;
      end
    end else if (tx_start) begin
      // Two frames, low byte first
      s.tx_sh  = {1'b1, tx_word[15:8], 1'b0, 1'b1, tx_word[7:0], 1'b0};
      s.tx_n   = NW'(sil_pkg::TX_BITS);
      s.tx_cnt = CW'(BIT_CYC - 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.tx_line <= 1'b1;
    end else begin
      st_r <= s;
    end
  end

  assign rx_valid = st_r.rx_v;
  assign rx_byte  = st_r.rx_b;
  assign tx_busy  = st_r.tx_n != '0;
  assign tx       = st_r.tx_line;

endmodule : sil_diag_link

// ### verilog/sil_top.sv
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module sil_top #(
  parameter int          ATTACH_CYC = sil_pkg::ATTACH_CYC,
  parameter int          BLINK_CYC  = sil_pkg::BLINK_CYC,
  parameter int          BIT_CYC    = sil_pkg::DIAG_BIT_CYC,
  // Arbitrary neutral value
  parameter logic [15:0] SERIAL     = sil_pkg::SERIAL_DEF
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [sil_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [sil_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  input  wire logic                       actuator_present,
  input  wire logic [15:0]                actuator_name,
  input  wire logic                       supply_ok,
  input  wire logic                       internal_fault,
  input  wire sil_pkg::sil_pair_s         safety_in,
  input  wire logic                       diag_in,
  output sil_pkg::sil_pair_s              safety_out,
  output logic                            signal_diag_out,
  output sil_pkg::sil_led_s               led
);

  localparam int AW = $clog2(ATTACH_CYC + 1);
  localparam int BW = $clog2(BLINK_CYC + 1);

  typedef enum logic [1:0] {PL_NORM, PL_UNEQ, PL_LOCK} sil_pl_e;

  typedef struct packed {
    sil_pl_e                   pl;
    logic                      perr;
    sil_pkg::sil_pair_s        prev;
    logic                      pres_d;
    logic                      link;
    logic [AW-1:0]             att_cnt;
    logic [BW-1:0]             blink_cnt;
    logic                      blink;
    sil_pkg::sil_ctrl_s        ctrl;
    logic [7:0]                teach;
    logic [15:0]               name;
    logic                      tx_start;
    logic [15:0]               tx_word;
    sil_pkg::sil_pair_s        sout;
    logic                      sig;
    sil_pkg::sil_led_s         led;
    logic                      aw_f;
    logic [sil_pkg::ADDR_W-1:0] aw_a;
    logic                      w_f;
    logic [31:0]               w_d;
    logic [3:0]                w_s;
    logic                      aw_rdy;
    logic                      w_rdy;
    logic                      ar_rdy;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } sil_top_s;

  sil_top_s st_r;
  sil_top_s s;

  logic [2:0]            sy;
  sil_pkg::sil_pair_s    in_p;
  logic                  diag_s;
  logic                  rx_valid;
  logic [7:0]            rx_byte;
  logic                  tx_busy;
  logic                  tx_line;

  // ==========================================================
  // Pin synchronisers and diagnostic link
  sil_sync #(.W(3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({diag_in, safety_in}),
    .q       (sy)
  );

  assign in_p   = sil_pkg::sil_pair_s'(sy[1:0]);
  assign diag_s = sy[2];

  // Receiver sees the line only once link mode is up
  sil_diag_link #(.BIT_CYC(BIT_CYC)) u_link (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rx       (diag_s | ~st_r.link),
    .tx_start (st_r.tx_start),
    .tx_word  (st_r.tx_word),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .tx_busy  (tx_busy),
    .tx       (tx_line)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [sil_pkg::ADDR_W-1:0] a);
    return a == sil_pkg::OFF_CTRL   || a == sil_pkg::OFF_STATUS ||
           a == sil_pkg::OFF_SERIAL || a == sil_pkg::OFF_TEACH  ||
           a == sil_pkg::OFF_NAME;
  endfunction : mapped

  // ==========================================================
  // Next state
  logic                  ready;
  logic                  both_lo;
  logic                  set_perr;
  logic                  clr_perr;
  logic                  en;
  logic [31:0]           wv;
  sil_pkg::sil_status_s  sts;
  sil_pkg::sil_cmd_s     cmd;

  always_comb begin
    s          = st_r;
    set_perr   = 1'b0;
    clr_perr   = 1'b0;
    wv         = '0;
    s.tx_start = 1'b0;
    ready      = supply_ok && !internal_fault;
    both_lo    = !in_p.ch1 && !in_p.ch2;
    cmd        = sil_pkg::sil_cmd_s'(rx_byte);

    // Input plausibility
    unique case (st_r.pl)
      PL_NORM: if (st_r.prev.ch1 && st_r.prev.ch2 &&
                   (in_p.ch1 ^ in_p.ch2)) begin
        s.pl = PL_UNEQ;
      end
      PL_UNEQ: if (both_lo) begin
        s.pl = PL_NORM;
      end else if (in_p.ch1 && in_p.ch2) begin
        s.pl     = PL_LOCK;
        set_perr = 1'b1;
      end
      PL_LOCK: if (both_lo) begin
        s.pl = PL_NORM;
      end
    endcase
    s.prev   = in_p;
    s.pres_d = actuator_present;

    // Safety outputs: any fallback drops both
    en = ready && actuator_present && !st_r.ctrl.force_safe &&
         st_r.pl != PL_LOCK;
    s.sout.ch1 = en && in_p.ch1;
    s.sout.ch2 = en && in_p.ch2;

    // Module attach: diag line held idle high long enough
    if (!st_r.link) begin
      if (!diag_s) begin
        s.att_cnt = '0;
      end else if (st_r.att_cnt == AW'(ATTACH_CYC - 1)) begin
        s.link = 1'b1;
      end else begin
        s.att_cnt = st_r.att_cnt + 1'b1;
      end
    end
    s.sig = st_r.link ? tx_line : actuator_present;

    // Indicator flashing
    if (st_r.blink_cnt == BW'(BLINK_CYC - 1)) begin
      s.blink_cnt = '0;
      s.blink     = !st_r.blink;
    end else begin
      s.blink_cnt = st_r.blink_cnt + 1'b1;
    end
    s.led.actuator  = actuator_present;
    s.led.in_green  = st_r.pl == PL_NORM && in_p.ch1 && in_p.ch2;
    s.led.in_yellow = st_r.pl != PL_NORM && st_r.blink;
    s.led.pwr_green = ready;
    s.led.fault_red = !ready;

    // Status view shared by bus and link
    sts         = '0;
    sts.ready   = ready;
    sts.link    = st_r.link;
    sts.perr    = st_r.perr;
    sts.lock    = st_r.pl == PL_LOCK;
    sts.unequal = st_r.pl == PL_UNEQ;
    sts.out2    = st_r.sout.ch2;
    sts.out1    = st_r.sout.ch1;
    sts.in2     = in_p.ch2;
    sts.in1     = in_p.ch1;
    sts.present = actuator_present;

    // Actuator short name, captured on arrival
    if (actuator_present && !st_r.pres_d) begin
      s.name = actuator_name;
    end

    // Link commands addressed to this chain member
    if (st_r.link && rx_valid && !tx_busy &&
        cmd.addr == st_r.ctrl.chain_addr) begin
      s.tx_start = 1'b1;
      case (cmd.code)
        sil_pkg::CMD_STATUS:
          s.tx_word = {st_r.ctrl.chain_addr, 2'h0, sts};
        sil_pkg::CMD_SERIAL:   s.tx_word = SERIAL;
        sil_pkg::CMD_TEACH:    s.tx_word = {8'h00, st_r.teach};
        sil_pkg::CMD_NAME:     s.tx_word = st_r.name;
        sil_pkg::CMD_NAME_UPD: begin
          s.name    = actuator_present ? actuator_name : 16'h0000;
          s.tx_word = s.name;
        end
        default: s.tx_start = 1'b0;
      endcase
    end

    // ========================================================
    // AXI4-Lite write
    if (awvalid && st_r.aw_rdy) begin
      s.aw_f = 1'b1;
      s.aw_a = awaddr;
    end
    if (wvalid && st_r.w_rdy) begin
      s.w_f = 1'b1;
      s.w_d = wdata;
      s.w_s = wstrb;
    end
    if (st_r.aw_f && st_r.w_f && !st_r.bvalid) begin
      s.aw_f   = 1'b0;
      s.w_f    = 1'b0;
      s.bvalid = 1'b1;
      s.bresp  = mapped(st_r.aw_a) ? sil_pkg::RESP_OKAY
                                   : sil_pkg::RESP_SLVERR;
      if (st_r.aw_a == sil_pkg::OFF_CTRL) begin
        wv     = merge(32'(st_r.ctrl), st_r.w_d, st_r.w_s);
        s.ctrl = sil_pkg::sil_ctrl_s'(wv[7:0]);
        s.ctrl.rsvd = '0;
      end else if (st_r.aw_a == sil_pkg::OFF_TEACH) begin
        wv      = merge(32'(st_r.teach), st_r.w_d, st_r.w_s);
        s.teach = wv[7:0];
      end else if (st_r.aw_a == sil_pkg::OFF_STATUS) begin
        clr_perr = st_r.w_s[0] && st_r.w_d[sil_pkg::STS_PERR_BIT];
      end
    end
    if (st_r.bvalid && bready) begin
      s.bvalid = 1'b0;
    end
    // Hardware set beats software clear
    s.perr = (st_r.perr && !clr_perr) || set_perr;

    // AXI4-Lite read
    if (arvalid && st_r.ar_rdy) begin
      s.rvalid = 1'b1;
      s.rresp  = mapped(araddr) ? sil_pkg::RESP_OKAY
                                : sil_pkg::RESP_SLVERR;
      unique case (araddr)
        sil_pkg::OFF_CTRL:   s.rdata = 32'(st_r.ctrl);
        sil_pkg::OFF_STATUS: s.rdata = 32'(sts);
        sil_pkg::OFF_SERIAL: s.rdata = 32'(SERIAL);
        sil_pkg::OFF_TEACH:  s.rdata = 32'(st_r.teach);
        sil_pkg::OFF_NAME:   s.rdata = 32'(st_r.name);
        default:             s.rdata = '0;
      endcase
    end else if (st_r.rvalid && rready) begin
      s.rvalid = 1'b0;
    end
    // One write and one read in flight at most
    s.aw_rdy = !s.aw_f && !s.bvalid;
    s.w_rdy  = !s.w_f && !s.bvalid;
    s.ar_rdy = !s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= '0;
      st_r.teach <= sil_pkg::TEACH_RST;
    end else begin
      st_r <= s;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign awready         = st_r.aw_rdy;
  assign wready          = st_r.w_rdy;
  assign bvalid          = st_r.bvalid;
  assign bresp           = st_r.bresp;
  assign arready         = st_r.ar_rdy;
  assign rvalid          = st_r.rvalid;
  assign rdata           = st_r.rdata;
  assign rresp           = st_r.rresp;
  assign safety_out      = st_r.sout;
  assign signal_diag_out = st_r.sig;
  assign led             = st_r.led;

endmodule : sil_top

// ### bench/sil_far.sv
`timescale 1ns/10ps
module sil_far #(
  parameter int BIT_CYC = 16
) (
  input  wire logic               aclk,
  input  wire logic               attach,
  input  wire sil_pkg::sil_pair_s safety_out,
  input  wire logic               signal_diag_out,
  output logic                    diag_in,
  output logic                    both_on,
  output logic                    disagree
);
  // ==========================================================
  // Line drive
  logic tx_r  = 1'b1;
  logic tgl_r = 1'b0;
  // Unattached line toggles, so no idle level looks like a module
  always @(posedge aclk) tgl_r <= !tgl_r;
  assign diag_in  = attach ? tx_r : tgl_r;
  assign both_on  = safety_out.ch1 & safety_out.ch2;
  assign disagree = safety_out.ch1 ^ safety_out.ch2;

  // ==========================================================
  // Frames, LSB first
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_r <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask : send_byte

  task recv_byte(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b  = 8'h00;
    for (int i = 0; i < 8 * BIT_CYC && !ok; i++) begin
      @(posedge aclk);
      ok = !signal_diag_out;
    end
    if (ok) begin
      repeat (BIT_CYC / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge aclk);
        b[i] = signal_diag_out;
      end
      repeat (BIT_CYC) @(posedge aclk);
      ok = signal_diag_out;
    end
  endtask : recv_byte
endmodule : sil_far

// ### bench/sil_chk_sva.sv
`timescale 1ns/10ps
module sil_chk #(
  parameter int ATTACH_CYC = 20
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               actuator_present,
  input  wire logic               supply_ok,
  input  wire logic               internal_fault,
  input  wire logic               diag_in,
  input  wire sil_pkg::sil_pair_s safety_in,
  input  wire sil_pkg::sil_pair_s safety_out,
  input  wire logic               signal_diag_out
);
  // ==========================================================
  // Mirror of the input monitor on synced samples
  logic [1:0] p1_r, p2_r, p3_r;
  logic       une_r, lk_r, lnk_r;
  int         hi_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {p1_r, p2_r, p3_r, une_r, lk_r, lnk_r} <= '0;
      hi_r <= 0;
    end else begin
      p1_r <= safety_in;
      p2_r <= p1_r;
      p3_r <= p2_r;
      hi_r <= diag_in ? hi_r + 1 : 0;
      // Raw count leads the synced one, so this errs early
      lnk_r <= lnk_r | (hi_r >= ATTACH_CYC - 2);
      if (p2_r == 2'b00) begin
        une_r <= 1'b0;
        lk_r  <= 1'b0;
      end else if (p3_r == 2'b11 && p2_r != 2'b11) begin
        une_r <= 1'b1;
      end else if (une_r && p2_r == 2'b11) begin
        lk_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  no_actuator_a: assert property (
    !$past(actuator_present) |-> safety_out == 2'b00)
    else $error("Output on without actuator");
  follow_one_a: assert property (
    safety_out.ch1 |-> $past(safety_in.ch1, 3) && $past(actuator_present))
    else $error("Channel one on without cause");
  follow_two_a: assert property (
    safety_out.ch2 |-> $past(safety_in.ch2, 3) && $past(actuator_present))
    else $error("Channel two on without cause");
  fault_off_a: assert property (
    $past(internal_fault) && $past(internal_fault, 2) |-> safety_out == 2'b00)
    else $error("Output on during fault");
  supply_off_a: assert property (
    !$past(supply_ok) && !$past(supply_ok, 2) |-> safety_out == 2'b00)
    else $error("Output on with bad supply");
  presence_level_a: assert property (
    !lnk_r && $past(aresetn) |-> signal_diag_out == $past(actuator_present))
    else $error("Signal output not presence level");
  lock_off_a: assert property (
    lk_r && $past(lk_r) |-> safety_out == 2'b00)
    else $error("Output on during lock");
  leave_off_a: assert property (
    $fell(actuator_present) |=> safety_out == 2'b00)
    else $error("Output on after actuator left");
endmodule : sil_chk

bind sil_top sil_chk #(.ATTACH_CYC(ATTACH_CYC)) chk (
  .aclk(aclk), .aresetn(aresetn), .actuator_present(actuator_present),
  .supply_ok(supply_ok), .internal_fault(internal_fault),
  .diag_in(diag_in), .safety_in(safety_in), .safety_out(safety_out),
  .signal_diag_out(signal_diag_out));

// ### bench/tb.sv
`timescale 1ns/10ps
module tb;
  // ==========================================================
  // Pins and counters
  localparam int BIT = 16;
  logic               aclk = 1'b0, aresetn = 1'b0;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         wstrb = 4'hf;
  logic               present = 1'b0, sup = 1'b1, flt = 1'b0;
  logic               attach = 1'b0;
  logic [15:0]        name = 16'hbeef;
  sil_pkg::sil_pair_s sin = 2'b00;
  sil_pkg::sil_pair_s sout;
  sil_pkg::sil_led_s  led;
  logic               awready, wready, bvalid, arready, rvalid;
  logic               diag, sig, ok1, ok2, both, dis;
  logic [1:0]         bresp, rresp, r;
  logic [31:0]        rdata, v;
  logic [7:0]         lo, hi;
  int                 n_errors = 0, compares = 0, k, n;
  // Rows: present, inputs, outputs, signal level
  logic [5:0] rows [8] = '{6'b111111, 6'b100001, 6'b011000, 6'b000000,
                           6'b110101, 6'b100001, 6'b101011, 6'b100001};

  always #50 aclk = !aclk;

  sil_top #(.ATTACH_CYC(20), .BLINK_CYC(8), .BIT_CYC(BIT)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .actuator_present(present), .actuator_name(name), .supply_ok(sup),
    .internal_fault(flt), .safety_in(sin), .diag_in(diag),
    .safety_out(sout), .signal_diag_out(sig), .led(led));
  sil_far #(.BIT_CYC(BIT)) far (
    .aclk(aclk), .attach(attach), .safety_out(sout),
    .signal_diag_out(sig), .diag_in(diag), .both_on(both), .disagree(dis));

  // ==========================================================
  // Tasks
  task tick(input int c);
    repeat (c) @(posedge aclk);
  endtask : tick

  task complete_run;
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      complete_run;
    end
  endtask : wr

  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      complete_run;
    end
  endtask : rd

  task poll(input logic [7:0] c, input logic [15:0] e, input logic ok);
    far.send_byte(c);
    far.recv_byte(lo, ok1);
    far.recv_byte(hi, ok2);
    chk(32'(ok1 & ok2), 32'(ok));
    if (ok) chk(32'({hi, lo}), 32'(e));
  endtask : poll

  // ==========================================================
  // Sequence
  initial begin
    tick(5);
    aresetn <= 1'b1;
    tick(2);
    rd(sil_pkg::OFF_TEACH);
    chk(v, 32'h8);
    rd(sil_pkg::OFF_SERIAL);
    chk(v, 32'(sil_pkg::SERIAL_DEF));
    rd(8'h14);
    chk(32'(r), 32'(sil_pkg::RESP_SLVERR));
    for (k = 0; k < 8; k++) begin
      present <= rows[k][5];
      sin     <= rows[k][4:3];
      tick(5);
      chk(32'(sout), 32'(rows[k][2:1]));
      chk(32'(sig), 32'(rows[k][0]));
      chk(32'(led.actuator), 32'(rows[k][5]));
    end
    sin <= 2'b11;
    wr(sil_pkg::OFF_CTRL, 32'h1);
    chk(32'(r), 32'(sil_pkg::RESP_OKAY));
    tick(3);
    chk(32'(sout), 32'h0);
    wr(sil_pkg::OFF_CTRL, 32'h0);
    tick(3);
    chk(32'(sout), 32'h3);
    chk(32'(both), 32'h1);
    chk(32'(led.in_green), 32'h1);
    sin <= 2'b01;
    tick(5);
    chk(32'(sout), 32'h1);
    chk(32'(dis), 32'h1);
    n = 0;
    // Both LED states must show within 24 cycles, three blink half-periods
    for (k = 0; k < 24; k++) begin
      tick(1);
      n += int'(led.in_yellow);
    end
    chk(32'(n > 0 && n < 24), 32'h1);
    rd(sil_pkg::OFF_STATUS);
    chk(32'(v[5]), 32'h1);
    sin <= 2'b11;
    tick(5);
    chk(32'(sout), 32'h0);
    rd(sil_pkg::OFF_STATUS);
    chk(32'(v[7:6]), 32'h3);
    sin <= 2'b00;
    tick(5);
    sin <= 2'b11;
    tick(5);
    chk(32'(sout), 32'h3);
    // Error flag clears only by a write of one
    wr(sil_pkg::OFF_STATUS, 32'h80);
    chk(32'(r), 32'(sil_pkg::RESP_OKAY));
    rd(sil_pkg::OFF_STATUS);
    chk(32'(v[7]), 32'h0);
    flt <= 1'b1;
    tick(5);
    chk(32'(sout), 32'h0);
    chk(32'(led.fault_red), 32'h1);
    flt <= 1'b0;
    sup <= 1'b0;
    tick(5);
    chk(32'(sout), 32'h0);
    chk(32'(led.pwr_green), 32'h0);
    sup    <= 1'b1;
    attach <= 1'b1;
    // Second pass checks the link comes back after a reset
    for (k = 0; k < 2; k++) begin
      aresetn <= 1'b0;
      tick(5);
      aresetn <= 1'b1;
      tick(30);
      wr(sil_pkg::OFF_CTRL, 32'h30);
      poll({4'h3, sil_pkg::CMD_STATUS}, 16'h331f, 1'b1);
      poll({4'h3, sil_pkg::CMD_SERIAL}, sil_pkg::SERIAL_DEF, 1'b1);
      poll({4'h3, sil_pkg::CMD_TEACH}, 16'h0008, 1'b1);
      poll({4'h3, sil_pkg::CMD_NAME}, 16'hbeef, 1'b1);
      poll({4'h3, sil_pkg::CMD_NAME_UPD}, 16'hbeef, 1'b1);
      poll({4'h5, sil_pkg::CMD_TEACH}, 16'h0000, 1'b0);
    end
    complete_run;
  end
endmodule : tb
